// ### core/hbridge_map.vh
`ifndef HBRIDGE_MAP_VH
`define HBRIDGE_MAP_VH
// =====================================================================
// register map (word offsets are byte addresses, 32-bit data)
`define CTRL_OFS        8'h00
`define CFG_OFS         8'h04
`define STATUS_OFS      8'h08
`define MODE_OFS        8'h0c
// control register fields
`define CTRL_OUT_EN     0
`define CTRL_SDIR_A     1
`define CTRL_SDIR_B     2
`define CTRL_HALF       3
`define CTRL_SRC_SER    4
`define CTRL_RESET      5'h00
// configuration register fields
`define CFG_SLEW_LSB    0
`define CFG_ILIM_LSB    4
`define SLEW_DEFAULT    3'h3
`define ILIM_DEFAULT    2'h1
// status flag positions
`define ST_CP_UV        0
`define ST_OV           1
`define ST_UV           2
`define ST_SHG_A        3
`define ST_SHP_A        4
`define ST_SHG_B        5
`define ST_SHP_B        6
`define ST_OPEN         7
`define ST_TWARN        8
`define ST_OT           9
`define ST_BITS         10
// operating modes
`define MODE_SLEEP      2'h0
`define MODE_STANDBY    2'h1
`define MODE_NORMAL     2'h2
`define MODE_FAULT      2'h3
// timing: minimum low time of the fault output at power-up
`define PO_NS           1000
`define CLK_NS          100
`define PO_CYCLES       ((`PO_NS + `CLK_NS - 1) / `CLK_NS)
// current-limit chopping periods in cycles
`define CHOP_PERIOD     8'h20
`define CHOP_PERIOD_HOT 8'h80
`endif

// ### core/chop_pwm.v
`timescale 1ns/1ns
`include "hbridge_map.vh"
// =====================================================================
// current-limit chopper: on overload, outputs stay off for the rest of
// the current period; a hot die stretches the period
module chop_pwm (
    input wire clk_i,         // system clock
    input wire resetn_i,      // async reset, active low
    input wire run_i,         // chopper active
    input wire over_limit_i,  // high-side current above limit
    input wire hot_i,         // thermal warning present
    output reg chop_off_o     // force outputs off this cycle
);
    reg [7:0] cnt_reg;
    wire [7:0] period = hot_i ? `CHOP_PERIOD_HOT : `CHOP_PERIOD;

    // period counter; chop latched until period wraps
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 8'h00;
            chop_off_o <= 1'b0;
        end else if (!run_i) begin
            cnt_reg <= 8'h00;
            chop_off_o <= 1'b0;
        end else begin
            if (cnt_reg >= period - 8'h01) begin
                cnt_reg <= 8'h00;
                chop_off_o <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
                if (over_limit_i)
                    chop_off_o <= 1'b1;
            end
        end
    end
endmodule // chop_pwm

// ### core/hbridge_mode_fault_supervisor.v
// Operation
// - sleep disables every internal function; the bus still answers and control and config keep their values
// - standby runs logic, outputs high impedance
// - normal mode; any fault enters fault mode
// - fault mode forces outputs off unless braking on overvoltage, flag low
// - wake edge powers up only above supply threshold
// - defaults 2.0 V/us slew, 7.0 A limit
// - slew rate has eight serial settings
// - current limit has four serial levels
// - overcurrent short shuts down immediately
// - high-side sense chops output above limit
// - thermal warning flag readable serially
// - thermal stress lowers chopping frequency
// - overtemperature disables outputs
// - full-bridge overvoltage brakes high side, flags
// - short, overtemp, undervoltage report and disable
// - pins and serial bits steer bridge outputs
// - serial selects half/full bridge, output enable
// - separate flags for every diagnostic
// - wake pin low: outputs off, flag low
// - power-up flag held minimum, then charge pump ok
// - clear by write, inhibit fall, wake rise
`timescale 1ns/1ns
`include "hbridge_map.vh"
module hbridge_mode_fault_supervisor #(
    parameter PO_CYC = `PO_CYCLES   // power-up minimum flag cycles
) (
    input wire clk_i,                        // system clock, 10 MHz
    input wire resetn_i,                     // async reset, active low
    input wire [3:0] avs_address_i,          // word address
    input wire avs_read_i,                   // read strobe
    input wire avs_write_i,                  // write strobe
    input wire [31:0] avs_writedata_i,       // write data
    input wire [3:0] avs_byteenable_i,       // byte enables
    output reg [31:0] avs_readdata_o,        // read data
    output reg avs_waitrequest_o,            // wait request
    input wire device_wake_pin_i,            // wake / enable pin
    input wire output_inhibit_pin_i,         // disable pin
    input wire direction_input_a_i,          // parallel direction a
    input wire direction_input_b_i,          // parallel direction b
    input wire main_supply_ok_i,             // main supply above threshold
    input wire charge_pump_ok_i,             // charge pump above uv level
    input wire [`ST_BITS-1:0] fault_det_i,   // live protection detectors
    input wire over_limit_i,                 // current above selected limit
    output reg bridge_output_a_o,            // high-side a on (else low-side)
    output reg bridge_output_b_o,            // high-side b on (else low-side)
    output reg bridge_output_a_en_o,         // output a driven
    output reg bridge_output_b_en_o,         // output b driven
    output reg fault_flag_n_o,               // fault status, active low
    output reg [2:0] slew_sel_o,             // selected slew rate
    output reg [1:0] ilim_sel_o,             // selected current limit
    output reg [1:0] mode_o,                 // operating mode
    output reg regulator_on_o                // internal regulators enabled
);
    // =================================================================
    // state
    reg [4:0] ctrl_reg;
    reg [`ST_BITS-1:0] status_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg wake_d_reg;
    reg inh_d_reg;
    reg [7:0] po_cnt_reg;
    reg status_wr_reg;
    wire chop_off;

    wire wake_rise = device_wake_pin_i & ~wake_d_reg;
    wire inh_fall = ~output_inhibit_pin_i & inh_d_reg;
    wire clr_evt = status_wr_reg | inh_fall | wake_rise;
    // hard faults: shorts, overtemp, supply undervoltage, charge pump
    wire [`ST_BITS-1:0] hard_mask = (10'h001 << `ST_CP_UV) | (10'h001 << `ST_UV)
        | (10'h001 << `ST_SHG_A) | (10'h001 << `ST_SHP_A)
        | (10'h001 << `ST_SHG_B) | (10'h001 << `ST_SHP_B)
        | (10'h001 << `ST_OT);
    wire hard_now = |(fault_det_i & hard_mask);
    wire ov_now = fault_det_i[`ST_OV];
    wire any_latched = |(status_reg & ~(10'h001 << `ST_TWARN));
    wire po_done = (po_cnt_reg >= PO_CYC[7:0]);

    // =================================================================
    // avalon slave: one wait cycle, answer on second edge
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
            ctrl_reg <= `CTRL_RESET;
            slew_sel_o <= `SLEW_DEFAULT;
            ilim_sel_o <= `ILIM_DEFAULT;
            status_wr_reg <= 1'b0;
        end else begin
            status_wr_reg <= 1'b0;
            if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                if (avs_write_i & avs_byteenable_i[0]) begin
                    case ({avs_address_i, 2'b00})
                        `CTRL_OFS: ctrl_reg <= avs_writedata_i[4:0];
                        `CFG_OFS: begin
                            slew_sel_o <= avs_writedata_i[`CFG_SLEW_LSB+2:`CFG_SLEW_LSB];
                            ilim_sel_o <= avs_writedata_i[`CFG_ILIM_LSB+1:`CFG_ILIM_LSB];
                        end
                        `STATUS_OFS: status_wr_reg <= 1'b1;
                        default: ;
                    endcase
                end
                case ({avs_address_i, 2'b00})
                    `CTRL_OFS: avs_readdata_o <= {27'h0, ctrl_reg};
                    `CFG_OFS: avs_readdata_o <= {26'h0, ilim_sel_o, 1'b0, slew_sel_o};
                    `STATUS_OFS: avs_readdata_o <= {22'h0, status_reg};
                    `MODE_OFS: avs_readdata_o <= {30'h0, mode_reg};
                    default: avs_readdata_o <= 32'h0;
                endcase
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    // =================================================================
    // pin edge history
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_d_reg <= 1'b0;
            inh_d_reg <= 1'b1;
        end else begin
            wake_d_reg <= device_wake_pin_i;
            inh_d_reg <= output_inhibit_pin_i;
        end
    end

    // =================================================================
    // sticky status: a live fault wins over a clear in the same cycle
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= {`ST_BITS{1'b0}};
        end else if (mode_reg == `MODE_SLEEP) begin
            status_reg <= {`ST_BITS{1'b0}};
        end else begin
            status_reg <= (clr_evt ? {`ST_BITS{1'b0}} : status_reg) | fault_det_i;
        end
    end

    // =================================================================
    // power-up minimum hold of the fault output
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            po_cnt_reg <= 8'h00;
        else if (mode_reg == `MODE_SLEEP)
            po_cnt_reg <= 8'h00;
        else if (!po_done)
            po_cnt_reg <= po_cnt_reg + 8'h01;
    end

    // =================================================================
    // mode machine
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            `MODE_SLEEP:
                if (wake_rise & main_supply_ok_i)
                    mode_next = `MODE_STANDBY;
            `MODE_STANDBY:
                if (!device_wake_pin_i)
                    mode_next = `MODE_SLEEP;
                else if (po_done & charge_pump_ok_i & ~any_latched)
                    mode_next = `MODE_NORMAL;
            `MODE_NORMAL:
                if (!device_wake_pin_i)
                    mode_next = `MODE_SLEEP;
                else if (hard_now | ov_now | any_latched)
                    mode_next = `MODE_FAULT;
            `MODE_FAULT:
                if (!device_wake_pin_i)
                    mode_next = `MODE_SLEEP;
                else if (clr_evt & ~hard_now & ~ov_now)
                    mode_next = `MODE_NORMAL;
            default: mode_next = `MODE_SLEEP;
        endcase
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            mode_reg <= `MODE_SLEEP;
        else
            mode_reg <= mode_next;
    end

    chop_pwm u_chop (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(mode_reg == `MODE_NORMAL),
        .over_limit_i(over_limit_i),
        .hot_i(fault_det_i[`ST_TWARN]),
        .chop_off_o(chop_off)
    );

    // =================================================================
    // output steering; all outputs registered
    reg dir_a;
    reg dir_b;
    reg drive;
    reg brake;
    reg half;
    always @* begin
        dir_a = ctrl_reg[`CTRL_SRC_SER] ? ctrl_reg[`CTRL_SDIR_A] : direction_input_a_i;
        dir_b = ctrl_reg[`CTRL_SRC_SER] ? ctrl_reg[`CTRL_SDIR_B] : direction_input_b_i;
        half = ctrl_reg[`CTRL_HALF];
        drive = (mode_reg == `MODE_NORMAL) & device_wake_pin_i & ~output_inhibit_pin_i
            & ctrl_reg[`CTRL_OUT_EN] & ~hard_now & ~chop_off;
        // overvoltage brakes only in full-bridge mode; half-bridge just stops
        brake = (mode_reg == `MODE_FAULT) & ov_now & ~half & ~hard_now
            & device_wake_pin_i;
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bridge_output_a_o <= 1'b0;
            bridge_output_b_o <= 1'b0;
            bridge_output_a_en_o <= 1'b0;
            bridge_output_b_en_o <= 1'b0;
            fault_flag_n_o <= 1'b0;
            mode_o <= `MODE_SLEEP;
            regulator_on_o <= 1'b0;
        end else begin
            mode_o <= mode_reg;
            regulator_on_o <= (mode_next != `MODE_SLEEP);
            if (brake) begin
                bridge_output_a_o <= 1'b1;
                bridge_output_b_o <= 1'b1;
                bridge_output_a_en_o <= 1'b1;
                bridge_output_b_en_o <= 1'b1;
            end else begin
                // standby, sleep and fault keep both outputs off
                bridge_output_a_o <= dir_a;
                bridge_output_b_o <= dir_b;
                bridge_output_a_en_o <= drive;
                bridge_output_b_en_o <= drive & ~half;
            end
            // flag low in fault, sleep, power-up, or inhibit high
            fault_flag_n_o <= (mode_reg == `MODE_NORMAL) & po_done & charge_pump_ok_i
                & ~any_latched & ~output_inhibit_pin_i & device_wake_pin_i;
        end
    end
endmodule // hbridge_mode_fault_supervisor

// ### tb/hbridge_checks_assertions.sv
`timescale 1ns/1ns
`include "hbridge_map.vh"
// ==========
// port checks of bus timing, modes and output shutdown
module hbridge_checks (
    input wire clk_i, // clock
    input wire resetn_i, // reset, active low
    input wire avs_read_i, // read strobe
    input wire avs_write_i, // write strobe
    input wire avs_waitrequest_o, // wait request
    input wire device_wake_pin_i, // wake pin
    input wire main_supply_ok_i, // supply ok
    input wire [`ST_BITS-1:0] fault_det_i, // detectors
    input wire bridge_output_a_en_o, // a driven
    input wire bridge_output_b_en_o, // b driven
    input wire fault_flag_n_o, // fault flag
    input wire [1:0] mode_o // mode
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // bus answers in one cycle and stands low only one cycle
    a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered");
    a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    // outputs change on the same edge as the mode
    // mode_o and the outputs are registered from the same mode, so they
    // are compared in one cycle; a pin seen at one edge shows two edges on
    a_wake_sleep: assert property (!device_wake_pin_i |-> ##2 mode_o == `MODE_SLEEP)
        else $error("wake low without sleep");
    a_sleep_dark: assert property (mode_o == `MODE_SLEEP |-> !bridge_output_a_en_o
        && !bridge_output_b_en_o && !fault_flag_n_o) else $error("sleep not dark");
    a_standby_hiz: assert property (mode_o == `MODE_STANDBY |->
        !bridge_output_a_en_o && !bridge_output_b_en_o) else $error("standby drives");
    a_fault_flag: assert property (mode_o == `MODE_FAULT |-> !fault_flag_n_o)
        else $error("fault flag released");
    // open load is left out: it reaches fault mode through its latched flag
    a_fault_entry: assert property ((device_wake_pin_i &&
        (fault_det_i[`ST_SHP_B:0] != 0 || fault_det_i[`ST_OT]))
        ##1 mode_o == `MODE_NORMAL |=> mode_o == `MODE_FAULT) else $error("fault not entered");
    a_no_supply_wake: assert property (mode_o == `MODE_SLEEP && !main_supply_ok_i
        |=> mode_o == `MODE_SLEEP) else $error("woke without supply");
    a_hot_off: assert property (fault_det_i[`ST_OT] |-> ##2
        (!bridge_output_a_en_o && !bridge_output_b_en_o)) else $error("hot outputs on");
endmodule // hbridge_checks
bind hbridge_mode_fault_supervisor hbridge_checks hbridge_checks_i (.clk_i, .resetn_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .device_wake_pin_i, .main_supply_ok_i,
    .fault_det_i, .bridge_output_a_en_o, .bridge_output_b_en_o, .fault_flag_n_o, .mode_o);

// ### tb/host_pins_model.sv
`timescale 1ns/1ns
// ==========
// host pins: a command reaches the pins just after a clock edge
module host_pins_model (
    input wire clk_i, // clock
    input wire [3:0] cmd_i, // wake, inhibit, dir a, dir b
    output reg [3:0] pins_o // same order, on the pins
);
    // inhibit idles high as its pull-up would hold it; the bench lowers
    // it before expecting the flag to release
    initial pins_o = 4'h4;
    always @(posedge clk_i) begin
        pins_o <= cmd_i;
    end
endmodule // host_pins_model

// ### tb/test_hbridge_mode_fault_supervisor.sv
`timescale 1ns/1ns
`include "hbridge_map.vh"
// ==========
// bench: bus tasks, pin commands and detector stimulus
module test_hbridge_mode_fault_supervisor;
    reg clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [3:0] adr = 4'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [3:0] cmd = 4'h4;
    reg sup_ok = 1'b0;
    reg cp_ok = 1'b0;
    reg [9:0] det = 10'h000;
    reg ovl = 1'b0;
    wire [31:0] rdat;
    wire wt, a, b, ea, eb, fl_n, ron;
    wire [3:0] pins;
    wire [2:0] slew;
    wire [1:0] ilim, mode;
    reg [31:0] q;
    integer fails = 0;
    integer compares = 0;
    integer i;
    initial forever #50 clk_i = ~clk_i;
    host_pins_model host_pins_model_i (.clk_i(clk_i), .cmd_i(cmd), .pins_o(pins));
    hbridge_mode_fault_supervisor hbridge_mode_fault_supervisor_i (.clk_i(clk_i),
        .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .device_wake_pin_i(pins[3]), .output_inhibit_pin_i(pins[2]),
        .direction_input_a_i(pins[1]), .direction_input_b_i(pins[0]),
        .main_supply_ok_i(sup_ok), .charge_pump_ok_i(cp_ok), .fault_det_i(det),
        .over_limit_i(ovl), .bridge_output_a_o(a), .bridge_output_b_o(b),
        .bridge_output_a_en_o(ea), .bridge_output_b_en_o(eb), .fault_flag_n_o(fl_n),
        .slew_sel_o(slew), .ilim_sel_o(ilim), .mode_o(mode), .regulator_on_o(ron));
    task complete_run;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // one bus cycle; values read right after an edge are the sampled ones
    task bus(input w, input [3:0] ad, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            adr <= ad;
            wr <= w;
            rd <= !w;
            wd <= d;
            @(posedge clk_i);
            while (wt !== 1'b0 && n < 20) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n == 20) fails = fails + 1;
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    // bounded wait for a mode, then two edges so outputs catch up
    task wmode(input [1:0] m);
        integer n;
        begin
            n = 0;
            while (mode !== m && n < 40) begin
                @(posedge clk_i);
                n = n + 1;
            end
            chk(mode, m);
            tick(2);
        end
    endtask
    initial begin
        #2000000;
        fails = fails + 1;
        complete_run;
    end
    // ==========
    // main sequence
    initial begin
        tick(3);
        resetn_i <= 1'b1;
        chk({slew, ilim}, {`SLEW_DEFAULT, `ILIM_DEFAULT});
        chk({mode, fl_n, ron}, 4'h0);
        bus(0, 4'h7, 0);
        chk(q, 0);
        cmd <= 4'h8;
        tick(4);
        chk(mode, `MODE_SLEEP);
        cmd <= 4'h0;
        sup_ok <= 1'b1;
        cp_ok <= 1'b1;
        tick(2);
        cmd <= 4'h8;
        wmode(`MODE_STANDBY);
        wmode(`MODE_NORMAL);
        chk({fl_n, ron}, 2'b11);
        for (i = 0; i < 8; i = i + 1) begin
            bus(1, 4'h1, {26'h0, i[1:0], 1'b0, i[2:0]});
            tick(2);
            chk({slew, ilim}, {i[2:0], i[1:0]});
        end
        bus(1, 4'h0, 32'h13);
        tick(2);
        chk({a, b, ea, eb}, 4'b1011);
        cmd <= 4'h9;
        bus(1, 4'h0, 32'h01);
        tick(3);
        chk({a, b, ea, eb}, 4'b0111);
        bus(1, 4'h0, 32'h09);
        tick(2);
        chk(eb, 0);
        bus(1, 4'h0, 32'h01);
        ovl <= 1'b1;
        // chopper phase is free running, so look for an off cycle in a window
        q = 32'h1;
        repeat (4) begin
            tick(1);
            if (ea === 1'b0) q = 32'h0;
        end
        chk(q, 32'h0);
        ovl <= 1'b0;
        tick(40);
        // each detector latches its own flag; only the warning keeps normal
        for (i = 0; i < 10; i = i + 1) begin
            det <= 10'h1 << i;
            tick(3);
            if (i > 1 && i != 7 && i != 8) chk({ea, eb}, 2'b00);
            if (i == 1) chk({a, b}, 2'b11);
            det <= 10'h0;
            bus(0, 4'h2, 0);
            chk(q, 32'h1 << i);
            chk(mode, (i == 8) ? `MODE_NORMAL : `MODE_FAULT);
            chk(fl_n, i == 8);
            bus(1, 4'h2, 0);
            wmode(`MODE_NORMAL);
            bus(0, 4'h2, 0);
            chk(q, 0);
        end
        det <= 10'h200;
        tick(2);
        bus(1, 4'h2, 0);
        tick(2);
        chk(mode, `MODE_FAULT);
        det <= 10'h0;
        cmd <= 4'hc;
        tick(3);
        cmd <= 4'h8;
        wmode(`MODE_NORMAL);
        cmd <= 4'h0;
        tick(4);
        chk({mode, fl_n, ea, eb}, 5'h00);
        complete_run;
    end
endmodule // test_hbridge_mode_fault_supervisor
